// *** bench/osd_row_position_size_colour_tb_top.sv ***
module osd_row_position_size_colour_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       lsync;
  logic       vsn;
  logic       dclk;
  logic       red;
  logic       grn;
  logic       blu;
  logic       bg;
  logic [7:0] mat;
  logic [7:0] ca;
  logic [7:0] ra[2];
  logic [7:0] rb[2];
  logic [7:0] txt[32];
  logic [7:0] fnt[64];
  int         miscompares;
  int         n_checks;
  int         cycles;

  osd_row_position_size_colour uut (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .line_sync_in(lsync), .vertical_sync_n_in(vsn),
    .display_dot_clk_in(dclk), .red_char_out(red), .green_char_out(grn), .blue_char_out(blu),
    .background_out(bg));

  tv_timing_model tv (.core_clk_in(clk), .rst_in(rst), .line_sync_out(lsync), .vertical_sync_n_out(vsn),
    .display_dot_clk_out(dclk), .phase_out(), .line_out(), .dot_out(), .prev_line_out(), .prev_dot_out());

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  function automatic logic [2:0] colour(input logic [1:0] c);
    case (c)
      2'h0: return {mat[0], mat[1], mat[0] | mat[1]};
      2'h1: return {mat[2], mat[2] | mat[3], mat[3]};
      2'h2: return {mat[4] | mat[5], mat[4], mat[5]};
      default: return {ca[5], ca[6], ca[7]};
    endcase
  endfunction

  // Expected {red, green, blue, background} for one dot
  function automatic logic [7:0] expect_px(input int ln, input int dt);
    logic [7:0] px;
    logic [7:0] t;
    logic [7:0] f;
    int         sp;
    int         h;
    int         w;
    int         rl;
    int         d;
    px = 8'h00;
    h = mat[6] ? 13 : 9;
    w = mat[7] ? 6 : 8;
    for (int k = 1; k >= 0; k--) begin
      sp = 2 * (ra[k][7:6] + 1);
      rl = ln - 4 * ra[k][5:0];
      d = dt - (4 * rb[k][5:0] + 5);
      if (rl >= 0 && rl < sp * h) begin
        px = 8'h00;
        if (rb[k][7] && d >= 0 && d < 16 * sp * w) begin
          t = txt[16 * k + d / (sp * w)];
          f = fnt[t[1:0] * 16 + rl / sp];
          if (f[7 - (d / sp) % w]) begin
            px[3:1] = colour(t[7:6]);
          end
          px[0] = rb[k][6];
        end
      end
    end
    return px;
  endfunction

  // Program one field's geometry and palette
  task automatic setup(input logic [7:0] m, input logic [7:0] a0, input logic [7:0] b0,
                       input logic [7:0] a1, input logic [7:0] b1);
    mat = m;
    ra[0] = a0;
    rb[0] = b0;
    ra[1] = a1;
    rb[1] = b1;
    wr_reg(osd_pkg::ADDR_MATRIX, m);
    wr_reg(osd_pkg::ADDR_ROW0_A, a0);
    wr_reg(osd_pkg::ADDR_ROW0_B, b0);
    wr_reg(osd_pkg::ADDR_ROW1_A, a1);
    wr_reg(osd_pkg::ADDR_ROW1_B, b1);
  endtask

  // Compare every dot of lines 0 to 29 of the next field, except the last dot of line 29
  task automatic check_field(input string name);
    while (tv.line_out != 31) @(negedge clk);
    while (tv.line_out != 0) @(negedge clk);
    while (tv.line_out != 30) begin
      @(negedge clk);
      // Phase 1: last dot of a line still stands before line sync clears it
      if (tv.phase_out == 2'h1 && tv.prev_line_out < 30) begin
        check({4'h0, red, grn, blu, bg}, expect_px(tv.prev_line_out, tv.prev_dot_out));
      end
    end
    $display("test %s done", name);
  endtask

  initial begin
    logic [7:0] v;
    logic [7:0] rst_val[6];
    rst_val = '{osd_pkg::RST_CTRL_A, osd_pkg::RST_ROW0_A, osd_pkg::RST_ROW0_B, osd_pkg::RST_MATRIX,
                osd_pkg::RST_ROW1_A, osd_pkg::RST_ROW1_B};
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    void'($urandom(32'hAE85));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values, read-back, unmapped and write-only reads
    for (int i = 0; i < 6; i++) begin
      rd_reg(8'h40 + 8'(i), v);
      check(v, rst_val[i]);
      v = 8'($urandom);
      if (i == 0) begin
        ca = v;
      end
      wr_reg(8'h40 + 8'(i), v);
      rd_reg(8'h40 + 8'(i), rst_val[i]);
      check(rst_val[i], v);
    end
    rd_reg(8'h00, v);
    check(v, 8'h00);
    rd_reg(osd_pkg::ADDR_TEXT_BASE, v);
    check(v, 8'h00);
    $display("test registers done");
    // Random font for characters 0 to 3 and random text
    wr_reg(osd_pkg::ADDR_FONT_LO, 8'h00);
    wr_reg(osd_pkg::ADDR_FONT_HI, 8'h00);
    for (int i = 0; i < 64; i++) begin
      fnt[i] = 8'($urandom);
      wr_reg(osd_pkg::ADDR_FONT_DATA, fnt[i]);
    end
    // Pointer stepped once per font byte; data port reads zero
    rd_reg(osd_pkg::ADDR_FONT_LO, v);
    check(v, 8'h40);
    rd_reg(osd_pkg::ADDR_FONT_HI, v);
    check(v, 8'h00);
    rd_reg(osd_pkg::ADDR_FONT_DATA, v);
    check(v, 8'h00);
    for (int i = 0; i < 32; i++) begin
      txt[i] = {2'($urandom), 4'h0, 2'($urandom)};
      wr_reg(osd_pkg::ADDR_TEXT_BASE + 8'(i), txt[i]);
    end
    // Narrow, short; row0 size 0 at line 4, row1 size 1 at line 24
    setup({2'b10, 6'($urandom)}, 8'h01, {2'b10, 6'd11}, {2'b01, 6'd6}, {2'b11, 6'd12});
    check_field("narrow");
    // Wide, tall; row0 size 2 from line 0, row1 out of range
    setup({2'b01, 6'($urandom)}, {2'b10, 6'd0}, {2'b11, 6'd20}, 8'hFF, {2'b01, 6'd11});
    check_field("tall");
    // Row0 disabled with background set, row1 size 3 at line 20
    setup({2'b10, 6'($urandom)}, 8'h00, {2'b01, 6'd11}, {2'b11, 6'd5}, {2'b10, 6'd11});
    check_field("large");
    close_out();
  end
endmodule

// *** bench/tv_timing_model.sv ***
// Far side: TV sync and dot clock source, reporting the dot under view
module tv_timing_model #(
  parameter int DOTS  = 144,
  parameter int LINES = 32
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // Video timing
  output logic            line_sync_out,
  output logic            vertical_sync_n_out,
  output logic            display_dot_clk_out,
  // Position
  output logic [1:0]      phase_out,
  output int              line_out,
  output int              dot_out,
  output int              prev_line_out,
  output int              prev_dot_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Four clocks per dot period; position moves at each dot clock rise
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      phase_out <= 2'h0;
      dot_out <= 0;
      line_out <= 0;
      prev_dot_out <= 0;
      prev_line_out <= 0;
    end else begin
      phase_out <= phase_out + 2'h1;
      if (phase_out == 2'h3) begin
        prev_dot_out <= dot_out;
        prev_line_out <= line_out;
        dot_out <= (dot_out == DOTS - 1) ? 0 : dot_out + 1;
        if (dot_out == DOTS - 1) begin
          line_out <= (line_out == LINES - 1) ? 0 : line_out + 1;
        end
      end
    end
  end

  // Dot clock high two clocks, low two
  assign display_dot_clk_out = (phase_out < 2'h2);
  // Line sync rises mid last dot, so the next dot is number 0
  assign line_sync_out = (dot_out == DOTS - 1 && phase_out >= 2'h2) || (dot_out < 4);
  // Field sync low across the start of line 0
  assign vertical_sync_n_out = !((line_out == LINES - 1 && dot_out >= 40) || (line_out == 0 && dot_out < 40));
endmodule

// *** hdl/osd_mem.sv ***
module osd_mem #(
  parameter int AW = 10
) (
  // Clock
  input wire logic core_clk_in,
  // Memory port
  osd_mem_if.mem   port
);

  logic [7:0] store [2**AW];

  // Write port, registered read
  always_ff @(posedge core_clk_in) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= store[port.rd_addr];
  end

endmodule

// *** hdl/osd_mem_if.sv ***
// Write and read port of one byte memory
interface osd_mem_if #(parameter int AW = 10);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wr_data;
  logic [AW-1:0] rd_addr;
  logic [7:0]    rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// *** hdl/osd_pkg.sv ***
package osd_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_TEXT_BASE = 8'h20;
  localparam logic [7:0] ADDR_TEXT_LAST = 8'h3F;
  localparam logic [7:0] ADDR_CTRL_A    = 8'h40;
  localparam logic [7:0] ADDR_ROW0_A    = 8'h41;
  localparam logic [7:0] ADDR_ROW0_B    = 8'h42;
  localparam logic [7:0] ADDR_MATRIX    = 8'h43;
  localparam logic [7:0] ADDR_ROW1_A    = 8'h44;
  localparam logic [7:0] ADDR_ROW1_B    = 8'h45;
  localparam logic [7:0] ADDR_FONT_LO   = 8'h46;
  localparam logic [7:0] ADDR_FONT_HI   = 8'h47;
  localparam logic [7:0] ADDR_FONT_DATA = 8'h48;
  localparam logic [7:0] ADDR_STATUS    = 8'h49;

  // Reset values
  localparam logic [7:0] RST_CTRL_A = 8'h04;
  localparam logic [7:0] RST_ROW0_A = 8'h00;
  localparam logic [7:0] RST_ROW0_B = 8'h04;
  localparam logic [7:0] RST_MATRIX = 8'h04;
  localparam logic [7:0] RST_ROW1_A = 8'h04;
  localparam logic [7:0] RST_ROW1_B = 8'h04;

  // Matrix and colour control fields
  localparam int BIT_DOT_W    = 7;
  localparam int BIT_DOT_H    = 6;
  localparam int BIT_P2_BLUE  = 5;
  localparam int BIT_P2_GREEN = 4;
  localparam int BIT_P1_BLUE  = 3;
  localparam int BIT_P1_RED   = 2;
  localparam int BIT_P0_GREEN = 1;
  localparam int BIT_P0_RED   = 0;
  // Control A fields
  localparam int BIT_P3_BLUE  = 7;
  localparam int BIT_P3_GREEN = 6;
  localparam int BIT_P3_RED   = 5;
  // Row A and row B fields, text byte fields
  localparam int BIT_SIZE_HI  = 7;
  localparam int BIT_SIZE_LO  = 6;
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_BGND     = 6;
  localparam int POS_LSB      = 0;
  localparam int POS_W        = 6;
  localparam int BIT_CODE_HI  = 7;
  localparam int BIT_CODE_LO  = 6;

  // Geometry
  localparam logic [2:0] W_LAST_NARROW = 3'h5;
  localparam logic [2:0] W_LAST_WIDE   = 3'h7;
  localparam logic [3:0] H_LAST_TALL   = 4'hC;
  localparam logic [3:0] H_LAST_SHORT  = 4'h8;
  localparam logic [8:0] HPOS_OFFSET   = 9'h005;
  localparam logic [3:0] CHAR_LAST     = 4'hF;
  localparam int         FONT_AW       = 10;
  localparam int         TEXT_AW       = 5;

  typedef enum {V_IDLE, V_ROW0, V_ROW1} vstate_t;
  typedef enum {H_WAIT, H_ACTIVE, H_DONE} hstate_t;

  // Last sub-count of one dot: 2, 4, 6 or 8 periods minus one
  function automatic logic [2:0] span_last(input logic [1:0] size);
    return {size, 1'b1};
  endfunction

  // First line of a row, four lines per step
  function automatic logic [8:0] vstart(input logic [5:0] pos);
    return {1'b0, pos, 2'b00};
  endfunction

  // First dot period of a row
  function automatic logic [8:0] hstart(input logic [5:0] pos);
    return {1'b0, pos, 2'b00} + HPOS_OFFSET;
  endfunction

  // Colour code to red, green, blue
  function automatic logic [2:0] palette(input logic [1:0] code, input logic [7:0] mat,
                                         input logic [7:0] ca);
    logic r;
    logic g;
    logic b;
    r = 1'b0;
    g = 1'b0;
    b = 1'b0;
    case (code)
      2'h0: begin
        r = mat[BIT_P0_RED];
        g = mat[BIT_P0_GREEN];
        b = r | g;
      end
      2'h1: begin
        r = mat[BIT_P1_RED];
        b = mat[BIT_P1_BLUE];
        g = r | b;
      end
      2'h2: begin
        g = mat[BIT_P2_GREEN];
        b = mat[BIT_P2_BLUE];
        r = g | b;
      end
      default: begin
        r = ca[BIT_P3_RED];
        g = ca[BIT_P3_GREEN];
        b = ca[BIT_P3_BLUE];
      end
    endcase
    return {r, g, b};
  endfunction

endpackage

// *** hdl/osd_row_position_size_colour.sv ***
// How it works
// - Width select one gives 6 dots, else 8
// - Height select one gives 13 dots, else 9
// - Row starts on line four times vertical field
// - Row starts at four times field plus five
// - Size code sets 2, 4, 6, 8 lines
// - Same code sets 2, 4, 6, 8 periods
// - Code 00: red, green bits, blue is OR
// - Code 01: red, blue bits, green is OR
// - Code 10: green, blue bits, red is OR
// - Code 11: three independent colour bits
// - Four codes give four colours per field
// - Font holds 13 by 8 dots per character
// - Row enable low silences all four outputs
// - Background bit adds background behind characters
//
// The plain strobed port is this design's own decision.
module osd_row_position_size_colour (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Video timing
  input  wire logic       line_sync_in,
  input  wire logic       vertical_sync_n_in,
  input  wire logic       display_dot_clk_in,
  // Video outputs
  output logic            red_char_out,
  output logic            green_char_out,
  output logic            blue_char_out,
  output logic            background_out
);

  logic [7:0]          ctrl_a_r;
  logic [7:0]          row0_a_r;
  logic [7:0]          row0_b_r;
  logic [7:0]          matrix_r;
  logic [7:0]          row1_a_r;
  logic [7:0]          row1_b_r;
  logic [9:0]          font_addr_r;
  logic                dot_prev_r;
  logic                line_prev_r;
  logic                vsync_prev_r;
  logic [8:0]          line_cnt_r;
  logic [8:0]          dot_cnt_r;
  osd_pkg::vstate_t    vstate_r;
  osd_pkg::hstate_t    hstate_r;
  logic [2:0]          vsub_r;
  logic [3:0]          vdot_r;
  logic [2:0]          hsub_r;
  logic [2:0]          hdot_r;
  logic [3:0]          char_r;
  logic                win_s1_r;
  logic                row_s1_r;
  logic [2:0]          hdot_s1_r;
  logic [3:0]          vdot_s1_r;
  logic                win_s2_r;
  logic                row_s2_r;
  logic [2:0]          hdot_s2_r;
  logic [1:0]          code_s2_r;
  logic                dot_tick;
  logic                line_tick;
  logic                field_tick;
  logic                row_sel;
  logic [7:0]          cur_a;
  logic [7:0]          cur_b;
  logic [2:0]          span_end;
  logic [2:0]          w_end;
  logic [3:0]          h_end;
  logic [8:0]          cur_hstart;
  logic                match0;
  logic                match1;
  osd_pkg::vstate_t    start_state;
  logic                dot_s2;
  logic                en_s2;
  logic                bg_s2;
  logic [2:0]          pal_s2;
  logic [7:0]          rd_value;

  osd_mem_if #(.AW(osd_pkg::TEXT_AW)) text_port ();
  osd_mem_if #(.AW(osd_pkg::FONT_AW)) font_port ();

  // Character codes with colour code per position
  osd_mem #(.AW(osd_pkg::TEXT_AW)) text_mem (
    .core_clk_in (core_clk_in),
    .port        (text_port)
  );

  // Font store, 16 slots per character of which 13 rows hold dots
  osd_mem #(.AW(osd_pkg::FONT_AW)) font_mem (
    .core_clk_in (core_clk_in),
    .port        (font_port)
  );

  // Edge detection of timing inputs
  assign dot_tick   = display_dot_clk_in & ~dot_prev_r;
  assign line_tick  = line_sync_in & ~line_prev_r;
  assign field_tick = ~vertical_sync_n_in & vsync_prev_r;

  // Current row fields and geometry
  assign row_sel    = (vstate_r == osd_pkg::V_ROW1);
  assign cur_a      = row_sel ? row1_a_r : row0_a_r;
  assign cur_b      = row_sel ? row1_b_r : row0_b_r;
  assign span_end   = osd_pkg::span_last(cur_a[osd_pkg::BIT_SIZE_HI:osd_pkg::BIT_SIZE_LO]);
  assign w_end      = matrix_r[osd_pkg::BIT_DOT_W] ? osd_pkg::W_LAST_NARROW : osd_pkg::W_LAST_WIDE;
  assign h_end      = matrix_r[osd_pkg::BIT_DOT_H] ? osd_pkg::H_LAST_TALL : osd_pkg::H_LAST_SHORT;
  assign cur_hstart = osd_pkg::hstart(cur_b[osd_pkg::POS_LSB +: osd_pkg::POS_W]);

  // Row start match on the line now beginning
  assign match0 = line_cnt_r == osd_pkg::vstart(row0_a_r[osd_pkg::POS_LSB +: osd_pkg::POS_W]);
  assign match1 = line_cnt_r == osd_pkg::vstart(row1_a_r[osd_pkg::POS_LSB +: osd_pkg::POS_W]);

  // Row 0 wins a tie; rows are kept apart by software
  always_comb begin
    start_state = osd_pkg::V_IDLE;
    if (match0) begin
      start_state = osd_pkg::V_ROW0;
    end else if (match1) begin
      start_state = osd_pkg::V_ROW1;
    end
  end

  // Control registers written by software
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_a_r <= osd_pkg::RST_CTRL_A;
      row0_a_r <= osd_pkg::RST_ROW0_A;
      row0_b_r <= osd_pkg::RST_ROW0_B;
      matrix_r <= osd_pkg::RST_MATRIX;
      row1_a_r <= osd_pkg::RST_ROW1_A;
      row1_b_r <= osd_pkg::RST_ROW1_B;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        osd_pkg::ADDR_CTRL_A: ctrl_a_r <= reg_wdata_in;
        osd_pkg::ADDR_ROW0_A: row0_a_r <= reg_wdata_in;
        osd_pkg::ADDR_ROW0_B: row0_b_r <= reg_wdata_in;
        osd_pkg::ADDR_MATRIX: matrix_r <= reg_wdata_in;
        osd_pkg::ADDR_ROW1_A: row1_a_r <= reg_wdata_in;
        osd_pkg::ADDR_ROW1_B: row1_b_r <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Font load pointer, steps on each font data write
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      font_addr_r <= 10'h000;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        osd_pkg::ADDR_FONT_LO:   font_addr_r[7:0] <= reg_wdata_in;
        osd_pkg::ADDR_FONT_HI:   font_addr_r[9:8] <= reg_wdata_in[1:0];
        osd_pkg::ADDR_FONT_DATA: font_addr_r <= font_addr_r + 10'h001;
        default: ;
      endcase
    end
  end

  // Memory write ports
  assign text_port.wr_en   = reg_wr_in && reg_addr_in >= osd_pkg::ADDR_TEXT_BASE &&
                             reg_addr_in <= osd_pkg::ADDR_TEXT_LAST;
  assign text_port.wr_addr = reg_addr_in[osd_pkg::TEXT_AW-1:0];
  assign text_port.wr_data = reg_wdata_in;
  assign font_port.wr_en   = reg_wr_in && reg_addr_in == osd_pkg::ADDR_FONT_DATA;
  assign font_port.wr_addr = font_addr_r;
  assign font_port.wr_data = reg_wdata_in;

  // Read decode
  always_comb begin
    rd_value = 8'h00;
    case (reg_addr_in)
      osd_pkg::ADDR_CTRL_A:  rd_value = ctrl_a_r;
      osd_pkg::ADDR_ROW0_A:  rd_value = row0_a_r;
      osd_pkg::ADDR_ROW0_B:  rd_value = row0_b_r;
      osd_pkg::ADDR_MATRIX:  rd_value = matrix_r;
      osd_pkg::ADDR_ROW1_A:  rd_value = row1_a_r;
      osd_pkg::ADDR_ROW1_B:  rd_value = row1_b_r;
      osd_pkg::ADDR_FONT_LO: rd_value = font_addr_r[7:0];
      osd_pkg::ADDR_FONT_HI: rd_value = {6'h00, font_addr_r[9:8]};
      osd_pkg::ADDR_STATUS:  rd_value = {5'h00, hstate_r == osd_pkg::H_ACTIVE,
                                         vstate_r == osd_pkg::V_ROW1, vstate_r == osd_pkg::V_ROW0};
      default:               rd_value = 8'h00;
    endcase
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_value : 8'h00;
    end
  end

  // Previous levels of timing inputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dot_prev_r   <= 1'b0;
      line_prev_r  <= 1'b0;
      vsync_prev_r <= 1'b1;
    end else begin
      dot_prev_r   <= display_dot_clk_in;
      line_prev_r  <= line_sync_in;
      vsync_prev_r <= vertical_sync_n_in;
    end
  end

  // Line number since vertical sync
  always_ff @(posedge core_clk_in) begin
    if (rst_in || field_tick) begin
      line_cnt_r <= 9'h000;
    end else if (line_tick) begin
      line_cnt_r <= line_cnt_r + 9'h001;
    end
  end

  // Dot periods since line start, saturating
  always_ff @(posedge core_clk_in) begin
    if (rst_in || line_tick) begin
      dot_cnt_r <= 9'h000;
    end else if (dot_tick && dot_cnt_r != 9'h1FF) begin
      dot_cnt_r <= dot_cnt_r + 9'h001;
    end
  end

  // Vertical walk through the active row
  always_ff @(posedge core_clk_in) begin
    if (rst_in || field_tick) begin
      vstate_r <= osd_pkg::V_IDLE;
      vsub_r   <= 3'h0;
      vdot_r   <= 4'h0;
    end else if (line_tick) begin
      case (vstate_r)
        osd_pkg::V_IDLE: begin
          vstate_r <= start_state;
          vsub_r   <= 3'h0;
          vdot_r   <= 4'h0;
        end
        osd_pkg::V_ROW0, osd_pkg::V_ROW1: begin
          if (vsub_r != span_end) begin
            vsub_r <= vsub_r + 3'h1;
          end else if (vdot_r != h_end) begin
            vsub_r <= 3'h0;
            vdot_r <= vdot_r + 4'h1;
          end else begin
            vstate_r <= start_state;
            vsub_r   <= 3'h0;
            vdot_r   <= 4'h0;
          end
        end
        default: vstate_r <= osd_pkg::V_IDLE;
      endcase
    end
  end

  // Horizontal walk across the sixteen characters
  always_ff @(posedge core_clk_in) begin
    if (rst_in || line_tick) begin
      hstate_r <= osd_pkg::H_WAIT;
      hsub_r   <= 3'h0;
      hdot_r   <= 3'h0;
      char_r   <= 4'h0;
    end else if (dot_tick) begin
      case (hstate_r)
        osd_pkg::H_WAIT: begin
          if (dot_cnt_r == cur_hstart) begin
            hstate_r <= osd_pkg::H_ACTIVE;
          end
        end
        osd_pkg::H_ACTIVE: begin
          if (hsub_r != span_end) begin
            hsub_r <= hsub_r + 3'h1;
          end else if (hdot_r != w_end) begin
            hsub_r <= 3'h0;
            hdot_r <= hdot_r + 3'h1;
          end else if (char_r != osd_pkg::CHAR_LAST) begin
            hsub_r <= 3'h0;
            hdot_r <= 3'h0;
            char_r <= char_r + 4'h1;
          end else begin
            hstate_r <= osd_pkg::H_DONE;
          end
        end
        osd_pkg::H_DONE: hstate_r <= osd_pkg::H_DONE;
        default: hstate_r <= osd_pkg::H_WAIT;
      endcase
    end
  end

  // Text fetch, then font fetch of the dot row
  assign text_port.rd_addr = {row_sel, char_r};
  assign font_port.rd_addr = {text_port.rd_data[5:0], vdot_s1_r};

  // Pipeline stages aligned with the memory reads
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      win_s1_r  <= 1'b0;
      row_s1_r  <= 1'b0;
      hdot_s1_r <= 3'h0;
      vdot_s1_r <= 4'h0;
      win_s2_r  <= 1'b0;
      row_s2_r  <= 1'b0;
      hdot_s2_r <= 3'h0;
      code_s2_r <= 2'h0;
    end else begin
      win_s1_r  <= vstate_r != osd_pkg::V_IDLE && hstate_r == osd_pkg::H_ACTIVE;
      row_s1_r  <= row_sel;
      hdot_s1_r <= hdot_r;
      vdot_s1_r <= vdot_r;
      win_s2_r  <= win_s1_r;
      row_s2_r  <= row_s1_r;
      hdot_s2_r <= hdot_s1_r;
      code_s2_r <= text_port.rd_data[osd_pkg::BIT_CODE_HI:osd_pkg::BIT_CODE_LO];
    end
  end

  // Dot, enables and colour of the dot now leaving the pipe
  assign dot_s2 = font_port.rd_data[3'h7 - hdot_s2_r];
  assign en_s2  = row_s2_r ? row1_b_r[osd_pkg::BIT_ENABLE] : row0_b_r[osd_pkg::BIT_ENABLE];
  assign bg_s2  = row_s2_r ? row1_b_r[osd_pkg::BIT_BGND] : row0_b_r[osd_pkg::BIT_BGND];
  assign pal_s2 = osd_pkg::palette(code_s2_r, matrix_r, ctrl_a_r);

  // Video outputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      red_char_out   <= 1'b0;
      green_char_out <= 1'b0;
      blue_char_out  <= 1'b0;
      background_out <= 1'b0;
    end else begin
      red_char_out   <= en_s2 && win_s2_r && dot_s2 && pal_s2[2];
      green_char_out <= en_s2 && win_s2_r && dot_s2 && pal_s2[1];
      blue_char_out  <= en_s2 && win_s2_r && dot_s2 && pal_s2[0];
      background_out <= en_s2 && win_s2_r && bg_s2;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  property p_width;
    hstate_r == osd_pkg::H_ACTIVE |-> hdot_r <= w_end;
  endproperty
  a_width: assert property (p_width) else $error("dot column past width");

  property p_height;
    vstate_r != osd_pkg::V_IDLE |-> vdot_r <= h_end;
  endproperty
  a_height: assert property (p_height) else $error("dot row past height");

  property p_vstart;
    line_tick && !field_tick && vstate_r == osd_pkg::V_IDLE &&
    line_cnt_r == {1'b0, row0_a_r[5:0], 2'b00} |=> vstate_r == osd_pkg::V_ROW0;
  endproperty
  a_vstart: assert property (p_vstart) else $error("row 0 missed its start line");

  property p_hstart;
    dot_tick && !line_tick && hstate_r == osd_pkg::H_WAIT &&
    dot_cnt_r == {1'b0, cur_b[5:0], 2'b00} + 9'h005 |=> hstate_r == osd_pkg::H_ACTIVE;
  endproperty
  a_hstart: assert property (p_hstart) else $error("row missed its start dot");

  property p_vspan;
    vstate_r != osd_pkg::V_IDLE |-> vsub_r <= {cur_a[7:6], 1'b1};
  endproperty
  a_vspan: assert property (p_vspan) else $error("line sub count past size");

  property p_hspan;
    line_tick ##1 (!line_tick)[*8] |-> hsub_r <= {cur_a[7:6], 1'b1};
  endproperty
  a_hspan: assert property (p_hspan) else $error("dot sub count past size");

  property p_colour;
    en_s2 && win_s2_r && dot_s2 |=> {red_char_out, green_char_out, blue_char_out} == $past(pal_s2);
  endproperty
  a_colour: assert property (p_colour) else $error("colour outputs off palette");

  property p_blank;
    !en_s2 |=> !(red_char_out || green_char_out || blue_char_out || background_out);
  endproperty
  a_blank: assert property (p_blank) else $error("output while row disabled");

  property p_no_bg;
    !bg_s2 |=> !background_out;
  endproperty
  a_no_bg: assert property (p_no_bg) else $error("background without its bit");

  property p_dots_only;
    (red_char_out || green_char_out || blue_char_out) |-> $past(dot_s2 && win_s2_r);
  endproperty
  a_dots_only: assert property (p_dots_only) else $error("colour outside a set dot");

  c_row0: cover property (vstate_r == osd_pkg::V_IDLE ##1 vstate_r == osd_pkg::V_ROW0);
  c_row1: cover property (vstate_r != osd_pkg::V_ROW1 ##1 vstate_r == osd_pkg::V_ROW1);
  c_white: cover property (red_char_out && green_char_out && blue_char_out);
  c_bg: cover property (background_out && !red_char_out);

endmodule
